// ---- verilog/mix_exec.sv ----
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module mix_exec
    import mix_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              op_valid,
    input  wire mix_op_t           op_code,
    input  wire logic [ADDR_W-1:0] op_addr,
    input  wire logic [2:0]        op_bit,
    input  wire logic [7:0]        op_imm,
    input  wire logic [3:0]        pc_page,
    input  wire logic [7:0]        table_pointer,
    input  wire logic [7:0]        mem_rdata,
    input  wire logic [ROM_DW-1:0] rom_rdata,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   mem_we,
    output logic [7:0]             mem_wdata,
    output logic [ROM_AW-1:0]      rom_addr,
    output logic                   busy,
    output logic                   skip_pulse,
    output logic                   discard_fetch,
    output logic [7:0]             acc,
    output logic [HIGH_W-1:0]      table_high_latch,
    output logic                   carry_flag,
    output logic                   aux_carry_flag,
    output logic                   zero_flag,
    output logic                   signed_wrap_flag
);
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DUMMY} mix_state_t;

    mix_state_t            state_ff;
    mix_state_t            nxt_state;
    mix_op_t               op_ff;
    logic [ADDR_W-1:0]     addr_ff;
    logic [2:0]            bit_ff;
    logic [7:0]            imm_ff;
    logic [7:0]            acc_ff;
    logic [7:0]            nxt_acc;
    logic                  acc_we;
    logic [3:0]            flags_ff;
    logic [3:0]            nxt_flags;
    logic [HIGH_W-1:0]     high_ff;
    logic                  we_ff;
    logic [7:0]            wdata_ff;
    logic                  nxt_we;
    logic [7:0]            nxt_wdata;
    logic                  skip_ff;
    logic                  take_skip;
    logic [7:0]            incr;
    logic [7:0]            swapped;
    logic [7:0]            bit_mask;
    logic                  sel_bit;
    logic [7:0]            sub_opnd;
    logic [7:0]            sub_diff;
    logic                  sub_c;
    logic                  sub_ac;
    logic                  sub_ov;
    logic [7:0]            xor_opnd;
    logic [7:0]            xor_res;

    // Operands arrive from memory one cycle after decode
    assign incr     = mem_rdata + 8'h01;
    assign swapped  = {mem_rdata[3:0], mem_rdata[7:4]};
    assign bit_mask = 8'h01 << bit_ff;
    assign sel_bit  = mem_rdata[bit_ff];

    always_comb
    begin
        sub_opnd = mem_rdata;
        xor_opnd = mem_rdata;
        if (op_ff == OP_MINUS_IMM)
        begin
            sub_opnd = imm_ff;
        end
        if (op_ff == OP_XOR_IMM)
        begin
            xor_opnd = imm_ff;
        end
    end
    assign xor_res = acc_ff ^ xor_opnd;

    mix_sub_alu u_sub (
        .acc         (acc_ff),
        .opnd        (sub_opnd),
        .diff        (sub_diff),
        .carry       (sub_c),
        .aux_carry   (sub_ac),
        .signed_wrap (sub_ov)
    );

    // Decode and result select in one place
    always_comb
    begin
        nxt_acc   = acc_ff;
        acc_we    = 1'b0;
        nxt_flags = flags_ff;
        nxt_we    = 1'b0;
        nxt_wdata = mem_rdata;
        take_skip = 1'b0;
        unique case (op_ff)
            OP_FILL_ONES:
            begin
                nxt_we    = 1'b1;
                nxt_wdata = ALL_ONES;
            end
            OP_BIT_SET:
            begin
                nxt_we    = 1'b1;
                nxt_wdata = mem_rdata | bit_mask;
            end
            OP_INCR_SKIP_ZERO:
            begin
                nxt_we    = 1'b1;
                nxt_wdata = incr;
                take_skip = (incr == 8'h00);
            end
            OP_INCR_TO_ACC_SKIP_ZERO:
            begin
                nxt_acc   = incr;
                acc_we    = 1'b1;
                take_skip = (incr == 8'h00);
            end
            OP_SKIP_BIT_HIGH:
            begin
                take_skip = sel_bit;
            end
            OP_MINUS_ACC, OP_MINUS_IMM, OP_MINUS_TO_MEM:
            begin
                if (op_ff == OP_MINUS_TO_MEM)
                begin
                    nxt_we    = 1'b1;
                    nxt_wdata = sub_diff;
                end
                else
                begin
                    nxt_acc = sub_diff;
                    acc_we  = 1'b1;
                end
                nxt_flags[FLAG_C]  = sub_c;
                nxt_flags[FLAG_AC] = sub_ac;
                nxt_flags[FLAG_Z]  = (sub_diff == 8'h00);
                nxt_flags[FLAG_OV] = sub_ov;
            end
            OP_NIBBLE_EXCHANGE:
            begin
                nxt_we    = 1'b1;
                nxt_wdata = swapped;
            end
            OP_NIBBLE_EXCHANGE_TO_ACC:
            begin
                nxt_acc = swapped;
                acc_we  = 1'b1;
            end
            OP_SKIP_IF_ZERO:
            begin
                take_skip = (mem_rdata == 8'h00);
            end
            OP_MOVE_SKIP_ZERO:
            begin
                nxt_acc   = mem_rdata;
                acc_we    = 1'b1;
                take_skip = (mem_rdata == 8'h00);
            end
            OP_SKIP_BIT_LOW:
            begin
                take_skip = ~sel_bit;
            end
            OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE:
            begin
                nxt_we    = 1'b1;
                nxt_wdata = rom_rdata[7:0];
            end
            OP_XOR_ACC, OP_XOR_IMM, OP_EXCLUSIVE_OR_TO_MEM:
            begin
                if (op_ff == OP_EXCLUSIVE_OR_TO_MEM)
                begin
                    nxt_we    = 1'b1;
                    nxt_wdata = xor_res;
                end
                else
                begin
                    nxt_acc = xor_res;
                    acc_we  = 1'b1;
                end
                nxt_flags[FLAG_Z] = (xor_res == 8'h00);
            end
            default:
            begin
                nxt_acc = acc_ff;
            end
        endcase
    end

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (op_valid)
                begin
                    nxt_state = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                // Skip costs a second, dummy cycle
                nxt_state = take_skip ? ST_DUMMY : ST_IDLE;
            end
            ST_DUMMY:
            begin
                nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            op_ff   <= OP_NOP;
            addr_ff <= '0;
            bit_ff  <= 3'h0;
            imm_ff  <= 8'h00;
        end
        else if (state_ff == ST_IDLE && op_valid)
        begin
            op_ff   <= op_code;
            addr_ff <= op_addr;
            bit_ff  <= op_bit;
            imm_ff  <= op_imm;
        end
        else if (state_ff == ST_EXEC)
        begin
            op_ff <= OP_NOP;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_ff   <= ACC_RST;
            flags_ff <= FLAGS_RST;
        end
        else if (state_ff == ST_EXEC)
        begin
            if (acc_we)
            begin
                acc_ff <= nxt_acc;
            end
            flags_ff <= nxt_flags;
        end
    end

    // Latch loads with the ROM word on the same clock edge as the registered memory write
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            high_ff <= HIGH_RST;
        end
        else if (state_ff == ST_EXEC &&
                 (op_ff == OP_TABLE_READ_CURRENT_PAGE ||
                  op_ff == OP_TABLE_READ_LAST_PAGE))
        begin
            high_ff <= rom_rdata[ROM_DW-1:DATA_W];
        end
    end

    // Write registered so the data output is a flip-flop
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            we_ff    <= 1'b0;
            wdata_ff <= 8'h00;
            skip_ff  <= 1'b0;
        end
        else
        begin
            we_ff    <= (state_ff == ST_EXEC) && nxt_we;
            wdata_ff <= nxt_wdata;
            skip_ff  <= (state_ff == ST_EXEC) && take_skip;
        end
    end

    // ROM page: current page from the core, or the fixed last page
    assign rom_addr = {((op_ff == OP_TABLE_READ_LAST_PAGE) ? PAGE_LAST
                                                           : pc_page),
                       table_pointer};
    assign mem_addr         = addr_ff;
    assign mem_we           = we_ff;
    assign mem_wdata        = wdata_ff;
    assign busy             = (state_ff != ST_IDLE);
    assign skip_pulse       = skip_ff;
    assign discard_fetch    = (state_ff == ST_DUMMY);
    assign acc              = acc_ff;
    assign table_high_latch = high_ff;
    assign carry_flag       = flags_ff[FLAG_C];
    assign aux_carry_flag   = flags_ff[FLAG_AC];
    assign zero_flag        = flags_ff[FLAG_Z];
    assign signed_wrap_flag = flags_ff[FLAG_OV];
endmodule
`default_nettype wire

// ---- pkg/mix_pkg.sv ----
package mix_pkg;
    localparam int DATA_W      = 8;
    localparam int ADDR_W      = 7;
    localparam int ROM_AW      = 12;
    localparam int ROM_DW      = 15;
    localparam int HIGH_W      = ROM_DW - DATA_W;
    localparam logic [7:0] ALL_ONES   = 8'hff;
    localparam logic [7:0] ACC_RST    = 8'h00;
    localparam logic [6:0] HIGH_RST   = 7'h00;
    localparam logic [7:0] PTR_RST    = 8'h00;
    localparam logic [3:0] PAGE_LAST  = 4'hf;
    // Status flag positions in the flag vector
    localparam int FLAG_C  = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_OV = 3;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    typedef enum logic [4:0] {
        OP_NOP,
        OP_FILL_ONES,
        OP_BIT_SET,
        OP_INCR_SKIP_ZERO,
        OP_INCR_TO_ACC_SKIP_ZERO,
        OP_SKIP_BIT_HIGH,
        OP_MINUS_ACC,
        OP_MINUS_TO_MEM,
        OP_MINUS_IMM,
        OP_NIBBLE_EXCHANGE,
        OP_NIBBLE_EXCHANGE_TO_ACC,
        OP_SKIP_IF_ZERO,
        OP_MOVE_SKIP_ZERO,
        OP_SKIP_BIT_LOW,
        OP_TABLE_READ_CURRENT_PAGE,
        OP_TABLE_READ_LAST_PAGE,
        OP_XOR_ACC,
        OP_EXCLUSIVE_OR_TO_MEM,
        OP_XOR_IMM
    } mix_op_t;
endpackage

// ---- verilog/mix_sub_alu.sv ----
`timescale 1ns/1ps
`default_nettype none
module mix_sub_alu
    import mix_pkg::*;
(
    input  wire logic [7:0] acc,
    input  wire logic [7:0] opnd,
    output logic [7:0]      diff,
    output logic            carry,
    output logic            aux_carry,
    output logic            signed_wrap
);
    logic [8:0] full;
    logic [4:0] low;
    // Two's-complement form: acc + ~opnd + 1
    assign full        = {1'b0, acc} + {1'b0, ~opnd} + 9'h001;
    assign low         = {1'b0, acc[3:0]} + {1'b0, ~opnd[3:0]} + 5'h01;
    assign diff        = full[7:0];
    assign carry       = full[8];
    assign aux_carry   = low[4];
    // Signed wrap when operands of unlike sign give a sign unlike acc
    assign signed_wrap = (acc[7] ^ opnd[7]) & (acc[7] ^ full[7]);
endmodule
`default_nettype wire

// ---- dv/mix_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module mix_props
    import mix_pkg::*;
(
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              op_valid,
    input wire mix_op_t           op_code,
    input wire logic [2:0]        op_bit,
    input wire logic [7:0]        table_pointer,
    input wire logic [7:0]        mem_rdata,
    input wire logic [ROM_DW-1:0] rom_rdata,
    input wire logic [ROM_AW-1:0] rom_addr,
    input wire logic              mem_we,
    input wire logic [7:0]        mem_wdata,
    input wire logic              busy,
    input wire logic              skip_pulse,
    input wire logic              discard_fetch,
    input wire logic [7:0]        acc,
    input wire logic [HIGH_W-1:0] table_high_latch,
    input wire logic              carry_flag,
    input wire logic              zero_flag
);
    mix_op_t    op_q_ff;
    logic [2:0] bit_q_ff;
    logic       hit;
    wire logic  ex = busy && !discard_fetch;
    wire logic  tbl = op_q_ff == OP_TABLE_READ_CURRENT_PAGE
                   || op_q_ff == OP_TABLE_READ_LAST_PAGE;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            op_q_ff <= OP_NOP;
        else if (op_valid && !busy)
            op_q_ff <= op_code;
    end

    // Only read while executing, so no reset needed
    always_ff @(posedge clk)
    begin
        if (op_valid && !busy)
            bit_q_ff <= op_bit;
    end

    always_comb
    begin
        case (op_q_ff)
            OP_INCR_SKIP_ZERO: hit = mem_rdata == 8'hff;
            OP_INCR_TO_ACC_SKIP_ZERO: hit = mem_rdata == 8'hff;
            OP_SKIP_BIT_HIGH: hit = mem_rdata[bit_q_ff];
            OP_SKIP_BIT_LOW: hit = !mem_rdata[bit_q_ff];
            OP_SKIP_IF_ZERO: hit = mem_rdata == 8'h00;
            OP_MOVE_SKIP_ZERO: hit = mem_rdata == 8'h00;
            default: hit = 1'b0;
        endcase
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_take(o);
        op_valid && !busy && op_code == o;
    endsequence

    a_skip_decision: assert property (
        ex |=> skip_pulse == $past(hit))
        else $error("skip decision wrong");
    a_dummy_cycle: assert property (
        skip_pulse |-> busy && discard_fetch ##1 !busy)
        else $error("dummy cycle wrong");
    a_fill_ones: assert property (
        s_take(OP_FILL_ONES) |=> ##1 mem_we && mem_wdata == ALL_ONES)
        else $error("fill value wrong");
    a_bit_set: assert property (
        ex && op_q_ff == OP_BIT_SET |=> mem_we
        && mem_wdata == ($past(mem_rdata) | (8'h01 << $past(bit_q_ff))))
        else $error("bit set wrong");
    a_incr_back: assert property (
        ex && op_q_ff == OP_INCR_SKIP_ZERO |=> mem_we
        && mem_wdata == 8'($past(mem_rdata) + 8'h01))
        else $error("increment wrong");
    a_sub_carry: assert property (
        ex && op_q_ff == OP_MINUS_ACC |=> acc == $past(acc - mem_rdata)
        && carry_flag == $past(acc >= mem_rdata))
        else $error("subtract wrong");
    a_swap_mem: assert property (
        ex && op_q_ff == OP_NIBBLE_EXCHANGE |=> mem_we
        && mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
        else $error("swap wrong");
    a_table_read: assert property (
        ex && tbl |=> mem_we && mem_wdata == $past(rom_rdata[7:0])
        && table_high_latch == $past(rom_rdata[14:8]))
        else $error("table read wrong");
    a_last_page: assert property (
        ex && op_q_ff == OP_TABLE_READ_LAST_PAGE
        |-> rom_addr == {PAGE_LAST, table_pointer})
        else $error("last page address wrong");
    a_xor_acc: assert property (
        ex && op_q_ff == OP_XOR_ACC |=> acc == $past(acc ^ mem_rdata)
        && zero_flag == (acc == 8'h00) && carry_flag == $past(carry_flag))
        else $error("xor wrong");
endmodule
bind mix_exec mix_props u_mix_props (.*);
`default_nettype wire

// ---- dv/mix_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mix_mem_model
    import mix_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic              mem_we,
    input  wire logic [7:0]        mem_wdata,
    input  wire logic [ROM_AW-1:0] rom_addr,
    output logic [7:0]             mem_rdata,
    output logic [ROM_DW-1:0]      rom_rdata
);
    logic [7:0] mem [128];
    assign mem_rdata = mem[mem_addr];
    // High part follows the page, so a wrong page shows in the latch
    assign rom_rdata = {rom_addr[11:5], rom_addr[7:0] ^ 8'ha5};
    // Plain always: the bench preloads bytes behind this process
    always @(posedge clk)
        if (mem_we)
            mem[mem_addr] <= mem_wdata;
endmodule
`default_nettype wire

// ---- dv/mix_exec_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
    checks++; \
    if ((g) !== (e)) \
    begin \
        err_count++; \
        $display("mismatch %s exp %h got %h", n, e, g); \
    end
module mix_exec_bench;
    import mix_pkg::*;
    logic clk, nrst, op_valid, mem_we, busy, skip_pulse, discard_fetch;
    logic carry_flag, aux_carry_flag, zero_flag, signed_wrap_flag, sk;
    mix_op_t           op_code;
    logic [ADDR_W-1:0] op_addr, mem_addr;
    logic [2:0]        op_bit;
    logic [3:0]        pc_page, fl0;
    logic [7:0]        op_imm, table_pointer, mem_rdata, mem_wdata, acc;
    logic [ROM_DW-1:0] rom_rdata;
    logic [ROM_AW-1:0] rom_addr;
    logic [HIGH_W-1:0] table_high_latch;
    int                err_count, checks, cyc;
    wire logic [3:0]   fl = {signed_wrap_flag, zero_flag, aux_carry_flag,
                             carry_flag};

    mix_exec u_mix_exec (.*);
    mix_mem_model u_mix_mem_model (.*);

    initial
    begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    function automatic logic [7:0] mem(int a);
        return u_mix_mem_model.mem[a];
    endfunction

    task automatic final_report;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Preload byte, issue one op, time it; returns at a negedge
    task automatic go(mix_op_t o, int a, logic [7:0] v, int b, int i, int s);
        u_mix_mem_model.mem[a] = v;
        fl0 = fl;
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= o;
        op_addr <= a[6:0];
        op_bit <= b[2:0];
        op_imm <= i[7:0];
        @(posedge clk);
        op_valid <= 1'b0;
        cyc = 0;
        sk = 0;
        do
        begin
            @(negedge clk);
            cyc++;
            sk |= skip_pulse;
        end while (busy && cyc < 6);
        if (busy)
        begin
            err_count++;
            final_report;
        end
        `CHK("skip", s[0], sk)
        `CHK("cycles", s ? 2 : 1, cyc - 1)
        @(negedge clk);
    endtask

    task automatic t_sub;
        go(OP_MOVE_SKIP_ZERO, 20, 8'h80, 0, 0, 0);
        go(OP_MINUS_IMM, 21, 8'h00, 0, 1, 0);
        `CHK("sub imm", 8'h7f, acc)
        `CHK("sub imm f", 4'b1001, fl)
        go(OP_MINUS_ACC, 21, 8'h80, 0, 0, 0);
        `CHK("sub", 8'hff, acc)
        `CHK("sub f", 4'b1010, fl)
        go(OP_MINUS_TO_MEM, 22, 8'hff, 0, 0, 0);
        `CHK("minus_to_mem", 8'h00, mem(22))
        `CHK("minus_to_mem acc", 8'hff, acc)
        `CHK("minus_to_mem f", 4'b0111, fl)
        $display("sub done");
    endtask

    task automatic t_fill;
        go(OP_FILL_ONES, 10, 8'h3c, 0, 0, 0);
        `CHK("fill", 8'hff, mem(10))
        `CHK("fill f", fl0, fl)
        go(OP_BIT_SET, 11, 8'h01, 7, 0, 0);
        `CHK("bit", 8'h81, mem(11))
        `CHK("bit f", fl0, fl)
        $display("fill done");
    endtask

    task automatic t_incr;
        go(OP_INCR_SKIP_ZERO, 12, 8'hff, 0, 0, 1);
        `CHK("incr", 8'h00, mem(12))
        go(OP_INCR_TO_ACC_SKIP_ZERO, 13, 8'h41, 0, 0, 0);
        `CHK("incr acc", 8'h42, acc)
        `CHK("incr mem", 8'h41, mem(13))
        `CHK("incr f", fl0, fl)
        go(OP_INCR_TO_ACC_SKIP_ZERO, 13, 8'hff, 0, 0, 1);
        `CHK("incr skip acc", 8'h00, acc)
        `CHK("incr skip mem", 8'hff, mem(13))
        $display("incr done");
    endtask

    task automatic t_skip;
        go(OP_SKIP_BIT_HIGH, 50, 8'h80, 7, 0, 1);
        go(OP_SKIP_BIT_HIGH, 50, 8'h7f, 7, 0, 0);
        go(OP_SKIP_BIT_LOW, 50, 8'hfe, 0, 0, 1);
        go(OP_SKIP_BIT_LOW, 50, 8'h01, 0, 0, 0);
        go(OP_SKIP_IF_ZERO, 50, 8'h00, 0, 0, 1);
        go(OP_SKIP_IF_ZERO, 50, 8'h01, 0, 0, 0);
        go(OP_MOVE_SKIP_ZERO, 50, 8'h00, 0, 0, 1);
        `CHK("mov acc", 8'h00, acc)
        `CHK("skip f", fl0, fl)
        $display("skip done");
    endtask

    task automatic t_swap;
        go(OP_NIBBLE_EXCHANGE, 30, 8'h3c, 0, 0, 0);
        `CHK("swap", 8'hc3, mem(30))
        go(OP_NIBBLE_EXCHANGE_TO_ACC, 31, 8'ha5, 0, 0, 0);
        `CHK("swap acc", 8'h5a, acc)
        `CHK("swap mem", 8'ha5, mem(31))
        `CHK("swap f", fl0, fl)
        $display("swap done");
    endtask

    task automatic t_table;
        @(posedge clk);
        pc_page <= 4'h2;
        table_pointer <= 8'h34;
        go(OP_TABLE_READ_CURRENT_PAGE, 40, 8'h00, 0, 0, 0);
        `CHK("tbl lo", 8'h91, mem(40))
        `CHK("tbl hi", 7'h11, table_high_latch)
        go(OP_TABLE_READ_LAST_PAGE, 41, 8'h00, 0, 0, 0);
        `CHK("tbl last", 7'h79, table_high_latch)
        $display("table done");
    endtask

    task automatic t_xor;
        go(OP_XOR_ACC, 60, 8'h5a, 0, 0, 0);
        `CHK("xor", 8'h00, acc)
        `CHK("xor f", {fl0[3], 1'b1, fl0[1:0]}, fl)
        go(OP_XOR_IMM, 60, 8'h5a, 0, 255, 0);
        `CHK("xori", 8'hff, acc)
        `CHK("xori f", {fl0[3], 1'b0, fl0[1:0]}, fl)
        go(OP_EXCLUSIVE_OR_TO_MEM, 61, 8'hff, 0, 0, 0);
        `CHK("exclusive_or_to_mem", 8'h00, mem(61))
        `CHK("exclusive_or_to_mem acc", 8'hff, acc)
        `CHK("exclusive_or_to_mem f", {fl0[3], 1'b1, fl0[1:0]}, fl)
        $display("xor done");
    endtask

    initial
    begin
        nrst = 0;
        op_valid = 0;
        op_code = OP_NOP;
        op_addr = '0;
        op_bit = '0;
        op_imm = '0;
        pc_page = '0;
        table_pointer = '0;
        repeat (4) @(posedge clk);
        nrst <= 1;
        t_sub;
        t_fill;
        t_incr;
        t_skip;
        t_swap;
        t_table;
        t_xor;
        final_report;
    end
endmodule
`default_nettype wire
